// [rbs_map.svh]
`ifndef RBS_MAP_SVH
`define RBS_MAP_SVH
// register word addresses (one 32-bit word each)
`define RBS_OFS_CTRL 2'h0
`define RBS_OFS_LEN 2'h1
`define RBS_OFS_OVR 2'h2
`define RBS_OFS_STAT 2'h3
// control word fields
`define RBS_CTRL_BURST 0
`define RBS_CTRL_TRIG 1
`define RBS_CTRL_W14 2
`define RBS_CTRL_PD 3
`define RBS_CTRL_FC_LO 4
`define RBS_CTRL_FC_HI 5
`define RBS_CTRL_RST 32'h0000_0005
// phase length exponent: 10 .. 25
`define RBS_LEN_MIN 5'd10
`define RBS_LEN_MAX 5'd25
`define RBS_LEN_RST 5'd10
// power-up start-up interval in samples
`define RBS_PWRUP_SAMPLES 27'd3072
// over-range threshold steps, 0 = 0 dBFS, 63 = -2.45 dBFS
`define RBS_OVR_STEP_CODES 16'd256
`define RBS_OVR_MAX_STEP 6'd63
`define RBS_OVR_RST 6'd0
`endif

// [rbs_pkg.sv]
`default_nettype none
package rbs_pkg;
  typedef enum logic [3:0] {
    RBS_IDLE = 4'b0001,
    RBS_START = 4'b0010,
    RBS_COARSE = 4'b0100,
    RBS_FINE = 4'b1000
  } rbs_state_t;
  typedef enum logic [1:0] {
    RBS_FC_021 = 2'h0,
    RBS_FC_025 = 2'h1,
    RBS_FC_029 = 2'h2
  } rbs_fc_t;
  typedef struct packed {
    logic [15:0] data;
    logic [3:0] width;
    logic fine;
    logic ovr;
  } rbs_word_t;
endpackage
`default_nettype wire

// [rbs_fifo_if.sv]
`default_nettype none
interface rbs_fifo_if #(parameter int W = 22);
  logic in_valid;
  logic in_ready;
  logic [W-1:0] in_data;
  logic out_valid;
  logic out_ready;
  logic [W-1:0] out_data;
  modport fill (output in_valid, output in_data, input in_ready,
                input out_valid, input out_data, output out_ready);
  modport buf_side (input in_valid, input in_data, output in_ready,
                    output out_valid, output out_data, input out_ready);
endinterface
`default_nettype wire

// [rbs_fifo.sv]
`default_nettype none
module rbs_fifo #(
  parameter int W = 22,
  parameter int DEPTH = 32
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  rbs_fifo_if.buf_side f
);
  localparam int AW = $clog2(DEPTH);
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_depth_chk
    $error("depth must be a power of two");
  end
  logic [W-1:0] mem [DEPTH];
  logic [AW:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic full, empty, push, pop;
  always_comb begin
    full = (wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]);
    empty = (wp_r == rp_r);
    push = f.in_valid && !full;
    pop = f.out_ready && !empty;
    wp_nxt = wp_r + (AW+1)'(push);
    rp_nxt = rp_r + (AW+1)'(pop);
    f.in_ready = !full;
    f.out_valid = !empty;
    f.out_data = mem[rp_r[AW-1:0]];
  end
  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wp_r[AW-1:0]] <= f.in_data;
    end
  end
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wp_r <= '0;
      rp_r <= '0;
    end else begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
    end
  end
endmodule
`default_nettype wire

// [rbs_sequencer.sv]
// The Avalon-MM interface to the registers and the placing of the registers are this design's own decisions.
`include "rbs_map.svh"
`default_nettype none
module rbs_sequencer #(
  parameter int FIFO_DEPTH = 32,
  parameter logic [26:0] PWRUP_SAMPLES = `RBS_PWRUP_SAMPLES
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic [1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  output logic [1:0] o_avs_response,
  input wire logic i_sample_valid,
  input wire logic [15:0] i_sample,
  input wire logic i_trigger,
  output logic o_trigger_ready,
  output logic o_sample_ready,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [15:0] o_out_data,
  output logic [3:0] o_out_width,
  output logic o_out_fine,
  output logic o_out_ovr,
  output logic [1:0] o_shaping_center_select
);
  import rbs_pkg::*;
  localparam int WW = $bits(rbs_word_t);
  // the buffer's pointers need a power-of-two depth
  if (FIFO_DEPTH < 2 || (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0) begin : g_depth_chk
    $error("fifo depth must be a power of two");
  end
  if (PWRUP_SAMPLES == 27'd0) begin : g_pwrup_chk
    $error("power-up interval must be nonzero");
  end

  // trigger pin crosses from outside: two flops before use
  logic trig_s1_r, trig_s2_r, trig_s3_r;
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      trig_s1_r <= 1'b0;
      trig_s2_r <= 1'b0;
      trig_s3_r <= 1'b0;
    end else begin
      trig_s1_r <= i_trigger;
      trig_s2_r <= trig_s1_r;
      trig_s3_r <= trig_s2_r;
    end
  end

  // configuration registers
  logic [31:0] ctrl_r, ctrl_nxt;
  logic [4:0] len_exp_r, len_exp_nxt;
  logic [5:0] ovr_step_r, ovr_step_nxt;
  logic ovr_sticky_r, ovr_sticky_nxt;
  logic rd_pend_r, rd_pend_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [1:0] resp_r, resp_nxt;
  logic restart_cfg, ovr_evt;
  rbs_state_t state_r, state_nxt;

  logic burst_en, trig_mode, w14, pd;
  always_comb begin
    burst_en = ctrl_r[`RBS_CTRL_BURST];
    trig_mode = ctrl_r[`RBS_CTRL_TRIG];
    w14 = ctrl_r[`RBS_CTRL_W14];
    pd = ctrl_r[`RBS_CTRL_PD];
    o_shaping_center_select = ctrl_r[`RBS_CTRL_FC_HI:`RBS_CTRL_FC_LO];
  end

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) r[i*8 +: 8] = wd[i*8 +: 8];
    end
    return r;
  endfunction

  // reads take one wait cycle; writes complete at once
  logic [31:0] wmerged;
  always_comb begin
    ctrl_nxt = ctrl_r;
    len_exp_nxt = len_exp_r;
    ovr_step_nxt = ovr_step_r;
    ovr_sticky_nxt = ovr_sticky_r | ovr_evt;
    rd_pend_nxt = 1'b0;
    rdata_nxt = rdata_r;
    resp_nxt = resp_r;
    restart_cfg = 1'b0;
    wmerged = 32'h0;
    o_avs_waitrequest = i_avs_read && !rd_pend_r;
    if (i_avs_write) begin
      resp_nxt = 2'h0;
      if (i_avs_address == `RBS_OFS_CTRL) begin
        wmerged = merge(ctrl_r, i_avs_writedata, i_avs_byteenable);
        ctrl_nxt = {26'h0, wmerged[5:0]};
        if (wmerged[`RBS_CTRL_FC_HI:`RBS_CTRL_FC_LO] == 2'h3) begin
          ctrl_nxt[`RBS_CTRL_FC_HI:`RBS_CTRL_FC_LO] = ctrl_r[`RBS_CTRL_FC_HI:`RBS_CTRL_FC_LO];
        end
        // soft power-up, width change, mode entry or sub-mode switch
        restart_cfg = (pd && !wmerged[`RBS_CTRL_PD])
                      || (w14 != wmerged[`RBS_CTRL_W14])
                      || (!burst_en && wmerged[`RBS_CTRL_BURST])
                      || (trig_mode != wmerged[`RBS_CTRL_TRIG]);
      end else if (i_avs_address == `RBS_OFS_LEN) begin
        wmerged = merge({27'h0, len_exp_r}, i_avs_writedata, i_avs_byteenable);
        // oversized values clamp high before their low bits reach the low check
        if (wmerged[31:5] != 27'h0 || wmerged[4:0] > `RBS_LEN_MAX) begin
          len_exp_nxt = `RBS_LEN_MAX;
        end else if (wmerged[4:0] < `RBS_LEN_MIN) begin
          len_exp_nxt = `RBS_LEN_MIN;
        end else begin
          len_exp_nxt = wmerged[4:0];
        end
      end else if (i_avs_address == `RBS_OFS_OVR) begin
        wmerged = merge({26'h0, ovr_step_r}, i_avs_writedata, i_avs_byteenable);
        ovr_step_nxt = wmerged[5:0];
      end else begin
        // status: write one to bit 0 clears sticky, a new event wins
        if (i_avs_byteenable[0] && i_avs_writedata[0]) ovr_sticky_nxt = ovr_evt;
      end
    end else if (i_avs_read && !rd_pend_r) begin
      rd_pend_nxt = 1'b1;
      resp_nxt = 2'h0;
      if (i_avs_address == `RBS_OFS_CTRL) begin
        rdata_nxt = ctrl_r;
      end else if (i_avs_address == `RBS_OFS_LEN) begin
        rdata_nxt = {27'h0, len_exp_r};
      end else if (i_avs_address == `RBS_OFS_OVR) begin
        rdata_nxt = {26'h0, ovr_step_r};
      end else begin
        rdata_nxt = {26'h0, state_r, o_trigger_ready, ovr_sticky_r};
      end
    end
  end
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ctrl_r <= `RBS_CTRL_RST;
      len_exp_r <= `RBS_LEN_RST;
      ovr_step_r <= `RBS_OVR_RST;
      ovr_sticky_r <= 1'b0;
      rd_pend_r <= 1'b0;
      rdata_r <= 32'h0;
      resp_r <= 2'h0;
    end else begin
      ctrl_r <= ctrl_nxt;
      len_exp_r <= len_exp_nxt;
      ovr_step_r <= ovr_step_nxt;
      ovr_sticky_r <= ovr_sticky_nxt;
      rd_pend_r <= rd_pend_nxt;
      rdata_r <= rdata_nxt;
      resp_r <= resp_nxt;
    end
  end
  assign o_avs_readdata = rdata_r;
  assign o_avs_response = resp_r;

  // phase sequencer, counted in accepted samples
  rbs_fifo_if #(.W(WW)) ff ();
  logic [26:0] cnt_r, cnt_nxt;
  logic [26:0] fine_len, coarse_len;
  logic fine_trig_r, fine_trig_nxt;
  logic take;
  always_comb begin
    fine_len = 27'(1) << len_exp_r;
    coarse_len = w14 ? 27'(3 * fine_len) : fine_len;
  end
  // stalls the converter path when the buffer is full
  assign o_sample_ready = ff.in_ready;
  assign take = i_sample_valid && ff.in_ready;

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    fine_trig_nxt = fine_trig_r;
    o_trigger_ready = 1'b0;
    case (state_r)
      RBS_IDLE: begin
        if (burst_en && !pd) begin
          state_nxt = RBS_START;
          cnt_nxt = 27'h0;
        end
      end
      RBS_START: begin
        if (take) begin
          cnt_nxt = cnt_r + 27'h1;
          if (cnt_r + 27'h1 >= coarse_len) begin
            // continuous goes straight to fine; triggered waits in coarse
            state_nxt = trig_mode ? RBS_COARSE : RBS_FINE;
            cnt_nxt = trig_mode ? coarse_len : 27'h0;
          end
        end
      end
      RBS_COARSE: begin
        // readiness once the coarse interval is complete
        o_trigger_ready = trig_mode && (cnt_r >= coarse_len);
        if (take && cnt_r < coarse_len) cnt_nxt = cnt_r + 27'h1;
        // leave on the last counted sample so no extra coarse word slips in
        if (!trig_mode && (cnt_r >= coarse_len
                           || (take && cnt_r + 27'h1 >= coarse_len))) begin
          state_nxt = RBS_FINE;
          cnt_nxt = 27'h0;
        end else if (trig_mode && o_trigger_ready && trig_s2_r && !trig_s3_r) begin
          state_nxt = RBS_FINE;
          cnt_nxt = 27'h0;
        end
      end
      RBS_FINE: begin
        if (take) begin
          cnt_nxt = cnt_r + 27'h1;
          if (cnt_r + 27'h1 >= fine_len) begin
            state_nxt = RBS_COARSE;
            cnt_nxt = 27'h0;
          end
        end
      end
      default: state_nxt = RBS_IDLE;
    endcase
    if (!burst_en || pd) begin
      state_nxt = RBS_IDLE;
    end else if (restart_cfg) begin
      state_nxt = RBS_START;
      cnt_nxt = 27'h0;
    end
    if (state_r == RBS_START && fine_trig_r) begin
      // power-up interval uses its own fixed count
      if (take) cnt_nxt = cnt_r + 27'h1;
      state_nxt = RBS_START;
      if (take && cnt_r + 27'h1 >= PWRUP_SAMPLES) begin
        state_nxt = trig_mode ? RBS_COARSE : RBS_FINE;
        cnt_nxt = trig_mode ? coarse_len : 27'h0;
        fine_trig_nxt = 1'b0;
      end
      if (!burst_en || pd) state_nxt = RBS_IDLE;
    end
  end
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_r <= RBS_IDLE;
      cnt_r <= 27'h0;
      fine_trig_r <= 1'b1;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      fine_trig_r <= fine_trig_nxt;
    end
  end

  // sample shaping and over-range window
  logic signed [16:0] half_win;
  rbs_word_t w;
  always_comb begin
    // window half-width shrinks 128 codes per step at each end
    half_win = 17'sd32768 - 17'(ovr_step_r * (`RBS_OVR_STEP_CODES >> 1));
    ovr_evt = take && (($signed({i_sample[15], i_sample}) >= half_win)
              || ($signed({i_sample[15], i_sample}) < -half_win));
    w.ovr = ovr_evt;
    w.fine = (state_r == RBS_FINE);
    if (w.fine) begin
      w.width = w14 ? 4'he : 4'hc;
      w.data = w14 ? {i_sample[15:2], 2'h0} : {i_sample[15:4], 4'h0};
    end else begin
      w.width = 4'h9;
      // shaping output clips to 9-bit full scale
      if (!burst_en && i_sample[15] == 1'b0 && i_sample[14:7] == 8'hff && i_sample[6]) begin
        w.data = 16'h7f80;
      end else begin
        w.data = {i_sample[15:7], 7'h0};
      end
    end
  end
  assign ff.in_valid = i_sample_valid;
  assign ff.in_data = w;
  assign ff.out_ready = !o_out_valid || i_out_ready;

  rbs_fifo #(.W(WW), .DEPTH(FIFO_DEPTH)) u_fifo (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .f(ff)
  );

  // registered output stage
  rbs_word_t ow_r, ow_nxt;
  logic ov_r, ov_nxt;
  always_comb begin
    ow_nxt = ow_r;
    ov_nxt = ov_r;
    if (ff.out_ready) begin
      ov_nxt = ff.out_valid;
      if (ff.out_valid) ow_nxt = ff.out_data;
    end
  end
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ow_r <= '0;
      ov_r <= 1'b0;
    end else begin
      ow_r <= ow_nxt;
      ov_r <= ov_nxt;
    end
  end
  assign o_out_valid = ov_r;
  assign o_out_data = ow_r.data;
  assign o_out_width = ow_r.width;
  assign o_out_fine = ow_r.fine;
  assign o_out_ovr = ow_r.ovr;
endmodule
`default_nettype wire

// [rbs_seq_props.sv]
`default_nettype none
module rbs_seq_props (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic o_avs_waitrequest,
  input wire logic [1:0] o_avs_response,
  input wire logic o_out_valid,
  input wire logic i_out_ready,
  input wire logic [15:0] o_out_data,
  input wire logic [3:0] o_out_width,
  input wire logic o_out_fine,
  input wire logic [1:0] o_shaping_center_select
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  sequence rd_first;
    i_avs_read && o_avs_waitrequest;
  endsequence
  sequence out_stall;
    o_out_valid && !i_out_ready;
  endsequence
  a_write_nowait: assert property (i_avs_write |-> !o_avs_waitrequest)
    else $error("write was stalled");
  a_read_wait: assert property ($rose(i_avs_read) |-> o_avs_waitrequest)
    else $error("read answered without a wait cycle");
  a_read_answer: assert property (rd_first |=> !o_avs_waitrequest)
    else $error("read wait longer than one cycle");
  a_resp_okay: assert property (o_avs_response == 2'h0)
    else $error("nonzero bus response");
  a_coarse_nine: assert property (
    o_out_valid && !o_out_fine |-> o_out_width == 4'h9 && o_out_data[6:0] == 7'h00)
    else $error("coarse sample not 9 bits");
  a_fine_width: assert property (
    o_out_valid && o_out_fine |-> (o_out_width == 4'hc && o_out_data[3:0] == 4'h0)
      || (o_out_width == 4'he && o_out_data[1:0] == 2'h0))
    else $error("fine sample width wrong");
  a_out_hold: assert property (
    out_stall |=> o_out_valid && $stable(o_out_data) && $stable(o_out_fine))
    else $error("output changed while stalled");
  a_center_legal: assert property (o_shaping_center_select != 2'h3)
    else $error("illegal shaping center");
endmodule
bind rbs_sequencer rbs_seq_props rbs_seq_props_i (
  .i_clk(i_clk),
  .i_rst_b(i_rst_b),
  .i_avs_read(i_avs_read),
  .i_avs_write(i_avs_write),
  .o_avs_waitrequest(o_avs_waitrequest),
  .o_avs_response(o_avs_response),
  .o_out_valid(o_out_valid),
  .i_out_ready(i_out_ready),
  .o_out_data(o_out_data),
  .o_out_width(o_out_width),
  .o_out_fine(o_out_fine),
  .o_shaping_center_select(o_shaping_center_select)
);
`default_nettype wire

// [rbs_sink.sv]
`default_nettype none
module rbs_sink (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_stall,
  input wire logic i_slow,
  output logic o_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic tog_r;
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) tog_r <= 1'b0;
    else tog_r <= !tog_r;
  end
  // slow mode takes every other word, stall holds the link back entirely
  assign o_ready = !i_stall && (!i_slow || tog_r);
endmodule
`default_nettype wire

// [testbench.sv]
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk = 0, i_rst_b = 0, i_avs_read = 0, i_avs_write = 0, i_trigger = 0;
  logic [1:0] i_avs_address = 0;
  logic [31:0] i_avs_writedata = 0, o_avs_readdata, q;
  logic o_avs_waitrequest, o_trigger_ready, o_sample_ready, o_out_valid, i_out_ready;
  logic [1:0] o_avs_response, o_shaping_center_select;
  logic i_sample_valid = 0, o_out_fine, o_out_ovr, stall = 0, slow = 0, cur_fine = 0;
  logic [15:0] i_sample = 0, o_out_data, smp = 16'h0100;
  logic [3:0] o_out_width, last_w = 0, fine_w = 0;
  logic last_ovr = 0;
  logic [15:0] last_d = 0;
  int error_cnt = 0, n_checks = 0, cyc = 0, acc_cnt = 0, feed_tgt = 0, out_cnt = 0, run_len = 0;
  int runs[$];
  localparam int PWR = 16;
  rbs_sequencer #(.PWRUP_SAMPLES(27'd16)) rbs_sequencer_i (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_avs_address(i_avs_address),
    .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
    .i_avs_byteenable(4'hf), .o_avs_readdata(o_avs_readdata),
    .o_avs_waitrequest(o_avs_waitrequest), .o_avs_response(o_avs_response),
    .i_sample_valid(i_sample_valid), .i_sample(i_sample), .i_trigger(i_trigger),
    .o_trigger_ready(o_trigger_ready), .o_sample_ready(o_sample_ready),
    .o_out_valid(o_out_valid), .i_out_ready(i_out_ready), .o_out_data(o_out_data),
    .o_out_width(o_out_width), .o_out_fine(o_out_fine), .o_out_ovr(o_out_ovr),
    .o_shaping_center_select(o_shaping_center_select));
  rbs_sink rbs_sink_i (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_stall(stall), .i_slow(slow), .o_ready(i_out_ready));
  initial begin
    forever #5 i_clk = !i_clk;
  end
  always @(posedge i_clk) begin
    if (i_sample_valid && o_sample_ready) acc_cnt <= acc_cnt + 1;
    i_sample_valid <= (acc_cnt + int'(i_sample_valid && o_sample_ready)) < feed_tgt;
    i_sample <= smp;
  end
  // run lengths of coarse and fine phases as seen on the output link
  always @(posedge i_clk) begin
    if (o_out_valid && i_out_ready) begin
      out_cnt <= out_cnt + 1;
      last_ovr <= o_out_ovr;
      last_d <= o_out_data;
      last_w <= o_out_width;
      if (o_out_fine) fine_w <= o_out_width;
      if (o_out_fine !== cur_fine) begin
        runs.push_back(run_len);
        run_len <= 1;
        cur_fine <= o_out_fine;
      end else run_len <= run_len + 1;
    end
  end
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      error_cnt++;
      close_out();
    end
  end
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [1:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_avs_write <= wr;
    i_avs_read <= !wr;
    i_avs_address <= a;
    i_avs_writedata <= d;
    do @(posedge i_clk); while (o_avs_waitrequest !== 1'b0);
    q = o_avs_readdata;
    i_avs_write <= 1'b0;
    i_avs_read <= 1'b0;
  endtask
  task automatic feed(input int n);
    @(negedge i_clk);
    feed_tgt = feed_tgt + n;
    while (acc_cnt != feed_tgt || out_cnt != acc_cnt) @(negedge i_clk);
  endtask
  task automatic clear();
    @(negedge i_clk);
    runs.delete();
    run_len = 0;
    cur_fine = 0;
  endtask
  task automatic t_powerup();
    @(posedge i_clk) stall <= 1'b1;
    feed_tgt = PWR + 1024 + 3072 + 1024 + 5;
    repeat (60) @(negedge i_clk);
    chk(acc_cnt, 33, "fifo fill count");
    chk(o_sample_ready, 1'b0, "ready while full");
    @(posedge i_clk) stall <= 1'b0;
    slow <= 1'b1;
    repeat (400) @(posedge i_clk);
    slow <= 1'b0;
    feed(0);
    chk(runs[0], PWR, "power-up start-up");
    chk(runs[1], 1024, "default fine length");
    chk(fine_w, 4'he, "fine width 14");
    chk(runs[2], 3072, "coarse length at 14");
    chk(runs[3], 1024, "second fine phase");
  endtask
  task automatic t_width12();
    clear();
    bus(1'b1, 2'h0, 32'h0000_0001);
    feed(3 * 1024 + 5);
    chk(runs[0], 1024, "start-up after width change");
    chk(runs[1], 1024, "fine length at 12");
    chk(fine_w, 4'hc, "fine width 12");
    chk(runs[2], 1024, "coarse length at 12");
  endtask
  task automatic t_trigger();
    clear();
    bus(1'b1, 2'h0, 32'h0000_0003);
    feed(1000);
    chk(o_trigger_ready, 1'b0, "ready before coarse length");
    feed(30);
    chk(o_trigger_ready, 1'b1, "ready after coarse length");
    // trigger only while ready is shown
    @(posedge i_clk) i_trigger <= 1'b1;
    repeat (4) @(posedge i_clk);
    i_trigger <= 1'b0;
    feed(1024 + 8);
    chk(runs[1], 1024, "triggered fine length");
  endtask
  task automatic t_shaping();
    logic [5:0] stp[6] = '{6'd1, 6'd1, 6'd1, 6'd1, 6'd63, 6'd63};
    logic [15:0] val[6] = '{16'h7f7f, 16'h7f80, 16'h8080, 16'h807f, 16'h607f, 16'h6080};
    logic exp[6] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
    for (int c = 0; c < 4; c++) begin
      bus(1'b1, 2'h0, {26'h0, 2'(c), 4'h0});
      repeat (2) @(posedge i_clk);
      chk(o_shaping_center_select, (c == 3) ? 2'h2 : 2'(c), "center select");
    end
    for (int k = 0; k < 6; k++) begin
      bus(1'b1, 2'h2, {26'h0, stp[k]});
      smp = val[k];
      feed(1);
      chk(last_ovr, exp[k], "over-range flag");
      chk(last_w, 4'h9, "shaping width");
      chk(last_d, val[k] & 16'hff80, "shaping data");
    end
    bus(1'b0, 2'h3, 32'h0);
    chk(q[0], 1'b1, "sticky over-range");
  endtask
  task automatic t_regs();
    logic [31:0] w[3] = '{32'd30, 32'd32, 32'd3};
    logic [31:0] e[3] = '{32'd25, 32'd25, 32'd10};
    for (int k = 0; k < 3; k++) begin
      bus(1'b1, 2'h1, w[k]);
      bus(1'b0, 2'h1, 32'h0);
      chk(q[4:0], e[k][4:0], "length clamp");
    end
  endtask
  task automatic t_softpwr();
    clear();
    bus(1'b1, 2'h0, 32'h0000_000d);
    bus(1'b1, 2'h0, 32'h0000_0005);
    feed(3072 + 1024 + 2);
    chk(runs[0], 3072, "start-up after soft power-up");
    chk(runs[1], 1024, "fine after soft power-up");
  endtask
  initial begin
    repeat (12) @(posedge i_clk);
    i_rst_b <= 1'b1;
    bus(1'b0, 2'h0, 32'h0);
    chk(q, 32'h0000_0005, "ctrl reset value");
    bus(1'b0, 2'h1, 32'h0);
    chk(q[4:0], 5'd10, "length reset value");
    t_powerup();
    t_width12();
    t_trigger();
    t_shaping();
    t_regs();
    t_softpwr();
    close_out();
  end
endmodule
`default_nettype wire
